// [hw/hpc_pkg.sv]
// Types shared by the host port block
`default_nettype none
package hpc_pkg;
  // Host bus personality
  typedef enum logic [1:0] {
    PERS_STROBE_PAIR,
    PERS_BUS16,
    PERS_BUS8,
    PERS_RSVD
  } hpc_pers_t;
  // Host port sequencer states
  typedef enum logic [1:0] {HP_IDLE, HP_READ, HP_WRITE} hpc_state_t;
  // Host side pins, sampled together
  typedef struct packed {
    logic       cs_hi;
    logic       cs_lo;
    logic       ds;
    logic       rw;
    logic [4:0] addr;
    logic [7:0] data;
    logic [1:0] tsel;
    logic       rst_n;
  } hpc_pins_t;
  // Decoded access phase
  typedef struct packed {
    logic act;
    logic rd;
  } hpc_acc_t;
endpackage
`default_nettype wire

// [hw/hpc_regs.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef HPC_REGS_SVH
`define HPC_REGS_SVH

// APB byte offsets, and the byte store base matched on address bits 11:7
`define HPC_CTRL_OFS   12'h000
`define HPC_STAT_OFS   12'h004
`define HPC_MASK_OFS   12'h008
`define HPC_INFO_OFS   12'h00c
`define HPC_MEM_BASE   5'h01
// Control register fields
`define HPC_CTRL_AMP   0
`define HPC_CTRL_GPO   1
`define HPC_CTRL_DIG   2
`define HPC_CTRL_RST   3'h0
// Event bits in status and mask
`define HPC_EV_WBD     0
`define HPC_EV_FRM     1
`define HPC_EV_HWR     2
`define HPC_EV_RST     3'h0
// Host address that returns and clears the interrupt flag
`define HPC_HIRQ_ADDR  5'h1f
// Power-up reset hold time and clock rate
`define HPC_POR_MS     10
`define HPC_CLK_MHZ    250
`define HPC_POR_CYC    (`HPC_POR_MS * `HPC_CLK_MHZ * 1000)

`endif

// [hw/hpc_top.sv]
// Host port configuration, reset generation and interrupt glue
`include "hpc_regs.svh"
`default_nettype none
module hpc_top #(
  parameter int unsigned POR_CYCLES = `HPC_POR_CYC,
  parameter int unsigned POR_W      = 22,
  parameter int unsigned DEPTH      = 32
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             irq_o,
  // Internal event sources
  input  wire logic        wbd_ready_i,
  input  wire logic        dsp_frame_i,
  // Host parallel port pins
  input  wire logic        host_cs_hi_i,
  input  wire logic        host_cs_lo_i,
  input  wire logic        host_data_strobe_i,
  input  wire logic        host_read_write_i,
  input  wire logic [4:0]  host_addr_i,
  input  wire logic [7:0]  host_data_i,
  output logic      [7:0]  host_data_o,
  output logic             host_data_oe_o,
  input  wire logic        host_type_sel0_i,
  input  wire logic        host_type_sel1_i,
  output logic             host_irq_o,
  // Reset and general outputs
  input  wire logic        reset_in_n_i,
  output logic             por_out_hi_o,
  output logic             por_out_lo_o,
  output logic             amp_enable_o,
  output logic             gp_output_o
);

  // Assertion clock and reset for every check below
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  // Personality from the type-select pair {sel1, sel0}
  function automatic hpc_pkg::hpc_pers_t pers_of(input logic [1:0] ts);
    hpc_pkg::hpc_pers_t p;
    p = hpc_pkg::PERS_RSVD;
    unique case (ts)
      2'b00: p = hpc_pkg::PERS_STROBE_PAIR;
      2'b10: p = hpc_pkg::PERS_BUS16;
      2'b01: p = hpc_pkg::PERS_BUS8;
      2'b11: p = hpc_pkg::PERS_RSVD;
    endcase
    return p;
  endfunction

  // Strobe and direction meaning per personality
  function automatic hpc_pkg::hpc_acc_t acc_of(
    input hpc_pkg::hpc_pers_t p, input logic ds, input logic rw);
    hpc_pkg::hpc_acc_t a;
    a = '0;
    unique case (p)
      hpc_pkg::PERS_STROBE_PAIR: begin
        a.act = ~ds | ~rw;  // Separate read and write strobes, low
        a.rd  = ~ds;
      end
      hpc_pkg::PERS_BUS16: begin
        a.act = ds;         // Enable clock high, rw high reads
        a.rd  = rw;
      end
      hpc_pkg::PERS_BUS8: begin
        a.act = ~ds;        // Data strobe low, rw high reads
        a.rd  = rw;
      end
      hpc_pkg::PERS_RSVD: a = '0;
    endcase
    return a;
  endfunction

  hpc_pkg::hpc_pins_t  pins_raw;
  hpc_pkg::hpc_pins_t  pins_s1;
  hpc_pkg::hpc_pins_t  pins_s2;
  hpc_pkg::hpc_state_t state;
  hpc_pkg::hpc_state_t next_state;
  logic [7:0]          mem [DEPTH];
  logic [4:0]          hp_addr;
  logic [7:0]          hp_wdata;
  logic [2:0]          ctrl;
  logic [2:0]          status;
  logic [2:0]          mask;
  logic                hirq_pend;
  logic [POR_W-1:0]    por_cnt;

  // Pin bundle, all pins pass two flip-flops
  assign pins_raw = '{cs_hi: host_cs_hi_i, cs_lo: host_cs_lo_i,
                      ds: host_data_strobe_i, rw: host_read_write_i,
                      addr: host_addr_i, data: host_data_i,
                      tsel: {host_type_sel1_i, host_type_sel0_i},
                      rst_n: reset_in_n_i};

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pins_s1 <= '0;
      pins_s2 <= '0;
    end else begin
      pins_s1 <= pins_raw;
      pins_s2 <= pins_s1;
    end
  end

  // Host side decode
  wire                     srst   = ~pins_s2.rst_n;
  wire hpc_pkg::hpc_pers_t pers   = pers_of(pins_s2.tsel);
  wire hpc_pkg::hpc_acc_t  acc    = acc_of(pers, pins_s2.ds,
                                           pins_s2.rw);
  wire                     sel    = pins_s2.cs_hi & ~pins_s2.cs_lo;
  wire                     busy   = sel & acc.act;
  wire                     start  = (state == hpc_pkg::HP_IDLE) & busy;
  wire                     wr_end = (state == hpc_pkg::HP_WRITE) & ~busy;
  wire                     hirq_rd = start & acc.rd &
                                     (pins_s2.addr == `HPC_HIRQ_ADDR);
  wire [7:0]               rd_val = (pins_s2.addr == `HPC_HIRQ_ADDR) ?
                                    {7'h00, hirq_pend} :
                                    mem[pins_s2.addr];
  wire                     pol_hi = (pers == hpc_pkg::PERS_STROBE_PAIR);

  // Host sequencer next state
  always_comb begin
    next_state = state;
    unique case (state)
      hpc_pkg::HP_IDLE:
        if (busy) begin
          next_state = acc.rd ? hpc_pkg::HP_READ : hpc_pkg::HP_WRITE;
        end
      hpc_pkg::HP_READ:
        if (!busy) begin
          next_state = hpc_pkg::HP_IDLE;
        end
      hpc_pkg::HP_WRITE:
        if (!busy) begin
          next_state = hpc_pkg::HP_IDLE;
        end
      default: next_state = hpc_pkg::HP_IDLE;
    endcase
  end

  // APB decode
  wire        setup    = psel_i & ~penable_i;
  wire        mem_hit  = (paddr_i[11:7] == `HPC_MEM_BASE);
  wire [4:0]  mem_idx  = paddr_i[6:2];
  wire        hit_ctrl = (paddr_i == `HPC_CTRL_OFS);
  wire        hit_stat = (paddr_i == `HPC_STAT_OFS);
  wire        hit_mask = (paddr_i == `HPC_MASK_OFS);
  wire        hit_info = (paddr_i == `HPC_INFO_OFS);
  wire        mapped   = mem_hit | hit_ctrl | hit_stat | hit_mask | hit_info;
  wire        apb_wr   = psel_i & penable_i & pready_o & pwrite_i & mapped;
  wire [31:0] info_val = {24'h000000, 2'b00, hirq_pend, ~por_out_hi_o,
                          state, pins_s2.tsel};
  wire [31:0] next_prdata =
    mem_hit  ? {24'h000000, mem[mem_idx]} :
    hit_ctrl ? {29'h00000000, ctrl} :
    hit_stat ? {29'h00000000, status} :
    hit_mask ? {29'h00000000, mask} :
    hit_info ? info_val : 32'h00000000;

  // Events: sticky status, host write counts as one
  wire [2:0] events  = {wr_end, dsp_frame_i, wbd_ready_i};
  wire [2:0] w1c     = (apb_wr & hit_stat) ? pwdata_i[2:0] : 3'h0;
  wire       hirq_ev = ctrl[`HPC_CTRL_DIG] ? dsp_frame_i
                                           : wbd_ready_i;

  // APB answer, no wait states
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h00000000;
    end else begin
      pready_o  <= setup;
      pslverr_o <= setup & ~mapped;
      prdata_o  <= setup ? next_prdata : 32'h00000000;
    end
  end

  // Control, status and mask registers
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl   <= `HPC_CTRL_RST;
      status <= `HPC_EV_RST;
      mask   <= `HPC_EV_RST;
    end else if (srst) begin
      ctrl   <= `HPC_CTRL_RST;
      status <= `HPC_EV_RST;
      mask   <= `HPC_EV_RST;
    end else begin
      if (apb_wr && hit_ctrl) begin
        ctrl <= pwdata_i[2:0];
      end
      if (apb_wr && hit_mask) begin
        mask <= pwdata_i[2:0];
      end
      status <= (status & ~w1c) | events;  // Set wins over clear
    end
  end

  // Host sequencer, data bus and interrupt flag
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state          <= hpc_pkg::HP_IDLE;
      hp_addr        <= 5'h00;
      hp_wdata       <= 8'h00;
      host_data_o    <= 8'h00;
      host_data_oe_o <= 1'b0;
      hirq_pend      <= 1'b0;
    end else if (srst) begin
      state          <= hpc_pkg::HP_IDLE;
      host_data_oe_o <= 1'b0;
      hirq_pend      <= 1'b0;
    end else begin
      state          <= next_state;
      host_data_oe_o <= (next_state == hpc_pkg::HP_READ);
      if (start) begin
        hp_addr     <= pins_s2.addr;
        host_data_o <= rd_val;
      end
      if (busy) begin
        hp_wdata <= pins_s2.data;
      end
      hirq_pend <= hirq_ev | (hirq_pend & ~hirq_rd);  // Set wins
    end
  end

  // Byte store, host writes win over APB
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= 8'h00;
      end
    end else if (srst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= 8'h00;
      end
    end else if (wr_end && hp_addr != `HPC_HIRQ_ADDR) begin
      mem[hp_addr] <= hp_wdata;
    end else if (apb_wr && mem_hit) begin
      mem[mem_idx] <= pwdata_i[7:0];
    end
  end

  // Power-up reset timer
  wire por_last = (por_cnt == POR_W'(POR_CYCLES - 1));

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      por_cnt      <= '0;
      por_out_hi_o <= 1'b1;
      por_out_lo_o <= 1'b0;
    end else if (por_out_hi_o) begin
      por_cnt      <= por_last ? por_cnt : por_cnt + 1'b1;
      por_out_hi_o <= ~por_last;
      por_out_lo_o <= por_last;
    end
  end

  // Output pins from flip-flops
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_o        <= 1'b0;
      host_irq_o   <= 1'b0;
      amp_enable_o <= 1'b0;
      gp_output_o  <= 1'b0;
    end else begin
      irq_o        <= |(status & mask);
      host_irq_o   <= pol_hi ? hirq_pend : ~hirq_pend;
      amp_enable_o <= ctrl[`HPC_CTRL_AMP];
      gp_output_o  <= ctrl[`HPC_CTRL_GPO];
    end
  end

  // Checks, clocked and reset-gated by the defaults at the top
  a_pers_bus16: assert property (
    pins_s2.tsel == 2'b10 |-> pers == hpc_pkg::PERS_BUS16)
    else $error("type select 10 not decoded as 16-bit bus");
  a_read_drive: assert property (
    (start && acc.rd && !srst) |=> host_data_oe_o)
    else $error("read access did not drive the data bus");
  a_write_commit: assert property (
    (wr_end && !srst) |=> status[`HPC_EV_HWR])
    else $error("host write did not raise its status bit");
  a_wbd_irq: assert property (
    (!ctrl[`HPC_CTRL_DIG] && wbd_ready_i && !srst) |=> ##1
    host_irq_o == $past(pol_hi))
    else $error("wide-band ready did not reach host interrupt");
  a_frame_irq: assert property (
    (ctrl[`HPC_CTRL_DIG] && dsp_frame_i && !srst) |=> hirq_pend)
    else $error("frame event did not set host interrupt");
  a_irq_pol: assert property (
    (hirq_pend && $past(hirq_pend) && $past(pins_s2.tsel) == 2'b01)
    |-> !host_irq_o)
    else $error("host interrupt polarity wrong for 8-bit bus");
  a_por_hold: assert property (
    (por_cnt < POR_W'(POR_CYCLES - 1)) |-> por_out_hi_o && !por_out_lo_o)
    else $error("power-up reset released early");
  a_por_release: assert property (
    por_last |=> !por_out_hi_o && por_out_lo_o)
    else $error("power-up reset not released at end of hold");
  a_soft_reset: assert property (
    srst |=> status == 3'h0 && !host_data_oe_o && ctrl == 3'h0)
    else $error("reset input did not clear the block");
  a_amp_follow: assert property (
    (apb_wr && hit_ctrl && !srst) |=> ##1
    amp_enable_o == $past(pwdata_i[`HPC_CTRL_AMP], 2))
    else $error("amplifier enable does not follow control write");
  a_gpo_follow: assert property (
    (apb_wr && hit_ctrl && !srst) |=> ##1
    gp_output_o == $past(pwdata_i[`HPC_CTRL_GPO], 2))
    else $error("general output does not follow control write");
  a_bus_float: assert property (
    state != hpc_pkg::HP_READ |-> !host_data_oe_o)
    else $error("data bus driven outside a read");

endmodule
`default_nettype wire

// [sim/hpc_host_model.sv]
// Microcontroller model driving the parallel host port pins
`default_nettype none
module hpc_host_model (
  // Clock and personality straps
  input  wire logic       clk_i,
  input  wire logic [1:0] tsel_i,
  // Device side of the data bus
  input  wire logic [7:0] dev_data_i,
  input  wire logic       dev_oe_i,
  // Pins toward the device
  output logic            cs_hi_o,
  output logic            cs_lo_o,
  output logic            ds_o,
  output logic            rw_o,
  output logic [4:0]      addr_o,
  output logic [7:0]      bus_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       drv = 1'h0;
  logic [7:0] wd = 8'h00;
  logic [7:0] last = 8'h00;

  // Pins deselected at time zero
  initial begin
    cs_hi_o = 1'h0;
    cs_lo_o = 1'h1;
    ds_o    = 1'h1;
    rw_o    = 1'h1;
    addr_o  = 5'h00;
  end

  // Undriven bus toggles so a stale value never passes
  assign bus_o = dev_oe_i ? dev_data_i : (drv ? wd : ~last);
  always @(posedge clk_i) last <= bus_o;

  // Rest levels of the selected personality, select dropped
  task automatic idle();
    cs_hi_o <= 1'h0;
    cs_lo_o <= 1'h1;
    ds_o    <= (tsel_i == 2'h2) ? 1'h0 : 1'h1;
    rw_o    <= 1'h1;
    drv     <= 1'h0;
  endtask

  // One byte access; ok falls if a read is not answered within 12 clocks
  task automatic access(input logic w, input logic [4:0] a,
                        input logic [7:0] d, output logic [7:0] q,
                        output logic ok);
    int n;
    q  = 8'h00;
    ok = 1'h1;
    cs_hi_o <= 1'h1;
    cs_lo_o <= 1'h0;
    addr_o  <= a;
    wd      <= d;
    drv     <= w;
    case (tsel_i)
      2'h0: begin
        if (w) rw_o <= 1'h0;
        else ds_o <= 1'h0;
      end
      2'h2: begin
        ds_o <= 1'h1;
        rw_o <= !w;
      end
      default: begin
        ds_o <= 1'h0;
        rw_o <= !w;
      end
    endcase
    n = 0;
    while (!w && dev_oe_i !== 1'h1 && n < 12) begin
      @(posedge clk_i);
      n++;
    end
    if (!w && n == 12) ok = 1'h0;
    else if (!w) q = dev_data_i;
    repeat (5) @(posedge clk_i);
    idle();
    repeat (6) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench for the host port block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'h0, rst_b = 1'h0, rin_n = 1'h1;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic        wideband_data_demod = 1'h0, dsp = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, irq, e, ok;
  logic        cs_hi, cs_lo, ds, rw, hoe, hirq, por_hi, por_lo, amp, gpo;
  logic [1:0]  tsel = 2'h0;
  logic [4:0]  haddr;
  logic [7:0]  hbus, hdo, hq;
  logic [1:0]  sels [3] = '{2'h0, 2'h2, 2'h1};
  int          n_mismatch = 0;
  int          n_compared = 0;

  // Clock at 250 MHz
  always #2 clk = ~clk;

  // Block under test with a short power-up hold
  hpc_top #(.POR_CYCLES(20)) i_hpc_top (
    .ref_clk_i(clk), .rst_b_i(rst_b),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq),
    .wbd_ready_i(wideband_data_demod), .dsp_frame_i(dsp),
    .host_cs_hi_i(cs_hi), .host_cs_lo_i(cs_lo),
    .host_data_strobe_i(ds), .host_read_write_i(rw),
    .host_addr_i(haddr), .host_data_i(hbus), .host_data_o(hdo),
    .host_data_oe_o(hoe), .host_type_sel0_i(tsel[0]),
    .host_type_sel1_i(tsel[1]), .host_irq_o(hirq),
    .reset_in_n_i(rin_n), .por_out_hi_o(por_hi), .por_out_lo_o(por_lo),
    .amp_enable_o(amp), .gp_output_o(gpo)
  );

  // Microcontroller on the far side
  hpc_host_model i_hpc_host_model (
    .clk_i(clk), .tsel_i(tsel), .dev_data_i(hdo), .dev_oe_i(hoe),
    .cs_hi_o(cs_hi), .cs_lo_o(cs_lo), .ds_o(ds), .rw_o(rw),
    .addr_o(haddr), .bus_o(hbus)
  );

  // Verdict and end of run
  task automatic close_out();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Word and bit comparisons
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x) begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, g, x);
    end
  endtask
  task automatic chk1(input logic g, input logic x);
    chk({31'h0, g}, {31'h0, x});
  endtask

  // APB transfer, then two idle cycles so registered outputs settle
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    q = prdata;
    e = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    if (n == 20) begin
      n_mismatch++;
      close_out();
    end
    repeat (2) @(posedge clk);
  endtask

  // Host access through the model
  task automatic host(input logic w, input logic [4:0] a,
                      input logic [7:0] d);
    i_hpc_host_model.access(w, a, d, hq, ok);
    chk1(ok, 1'h1);
  endtask

  // One-cycle event pulse, then time for the flag to show
  task automatic pulse(input logic w);
    if (w) wideband_data_demod <= 1'h1;
    else dsp <= 1'h1;
    @(posedge clk);
    wideband_data_demod <= 1'h0;
    dsp <= 1'h0;
    repeat (3) @(posedge clk);
  endtask

  // Reset with a personality strapped; power-up outputs held
  task automatic do_reset(input logic [1:0] s);
    rst_b <= 1'h0;
    tsel  <= s;
    repeat (10) @(posedge clk);
    i_hpc_host_model.idle();
    chk({30'h0, por_hi, por_lo}, 32'h2);
    rst_b <= 1'h1;
    repeat (6) @(posedge clk);
    chk({30'h0, por_hi, por_lo}, 32'h2);
  endtask

  // Interrupt sources, polarity, mask and clear paths
  task automatic t_irq(input logic [1:0] s);
    logic a;
    a = (s == 2'h0);
    chk1(hirq, !a);
    apb(1'h1, 12'h000, 32'h0);
    pulse(1'h0);
    chk1(hirq, !a);
    pulse(1'h1);
    chk1(hirq, a);
    chk1(irq, 1'h0);
    apb(1'h0, 12'h004, 32'h0);
    chk(q, 32'h3);  // Frame bit sticks in analog mode too
    apb(1'h1, 12'h008, 32'h1);
    chk1(irq, 1'h1);
    apb(1'h1, 12'h004, 32'h1);
    chk1(irq, 1'h0);
    host(1'h0, 5'h1f, 8'h00);
    chk({24'h0, hq}, 32'h1);
    chk1(hirq, !a);
    apb(1'h1, 12'h000, 32'h4);
    pulse(1'h1);
    chk1(hirq, !a);
    pulse(1'h0);
    chk1(hirq, a);
    host(1'h0, 5'h1f, 8'h00);
    chk1(hirq, !a);
  endtask

  // Host writes and reads in the strapped personality
  task automatic t_host(input logic [1:0] s);
    host(1'h1, 5'h15, {6'h29, s});
    host(1'h1, 5'h05, 8'h3c);
    host(1'h1, 5'h1f, 8'h5a);
    apb(1'h0, 12'h0fc, 32'h0);
    chk(q, 32'h0);
    apb(1'h0, 12'h0d4, 32'h0);
    chk(q, {24'h0, 6'h29, s});
    apb(1'h0, 12'h094, 32'h0);
    chk(q, 32'h3c);
    apb(1'h0, 12'h004, 32'h0);
    chk1(q[2], 1'h1);
    apb(1'h1, 12'h004, 32'h4);
    host(1'h0, 5'h15, 8'h00);
    chk({24'h0, hq}, {24'h0, 6'h29, s});
    chk1(hoe, 1'h0);
    apb(1'h0, 12'h004, 32'h0);
    chk1(q[2], 1'h0);
  endtask

  // Control outputs, unmapped access and reset input
  task automatic t_ctrl();
    apb(1'h1, 12'h000, 32'h3);
    chk({30'h0, amp, gpo}, 32'h3);
    apb(1'h1, 12'h000, 32'h2);
    chk({30'h0, amp, gpo}, 32'h1);
    apb(1'h0, 12'h040, 32'h0);
    chk({q[30:0], e}, 32'h1);
    chk({30'h0, por_hi, por_lo}, 32'h1);
    rin_n <= 1'h0;
    repeat (4) @(posedge clk);
    rin_n <= 1'h1;
    repeat (4) @(posedge clk);
    chk1(gpo, 1'h0);
    apb(1'h0, 12'h000, 32'h0);
    chk(q, 32'h0);
    chk({30'h0, por_hi, por_lo}, 32'h1);
  endtask

  // Main sequence over the three personalities
  initial begin
    for (int k = 0; k < 3; k++) begin
      do_reset(sels[k]);
      t_irq(sels[k]);
      t_host(sels[k]);
    end
    t_ctrl();
    close_out();
  end
endmodule
`default_nettype wire
